// File: rtl/can_mailbox_tx_request_control.sv
// mailbox enable, direction, transmit request, cancel and arbitration with axi4-lite access
`timescale 1ns/100ps
`default_nettype none
`include "can_mbox_map.svh"
module can_mailbox_tx_request_control
    import can_mbox_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int NUM_MB = 16,
    parameter int ID_W = 11,
    parameter int DLC_W = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic tx_req,
    output logic [$clog2(NUM_MB)-1:0] tx_mailbox,
    output logic [ID_W-1:0] tx_id,
    output logic [DLC_W-1:0] tx_dlc,
    input wire logic tx_start,
    input wire logic tx_ok,
    input wire logic tx_fail,
    input wire logic rx_active,
    input wire logic [$clog2(NUM_MB)-1:0] rx_mailbox,
    output logic rx_stop
);
    localparam int MB_W = $clog2(NUM_MB);
    localparam int WA_W = ADDR_W - 2;

    ////////////////////////////////////////////////////////////////////////////
    // decoding shared by the read and write paths
    function automatic logic is_mapped(input logic [WA_W-1:0] w);
        is_mapped = (w >= `IDX_ENABLE_LO && w <= `IDX_ABT_HI) ||
                    (w >= `IDX_SELECT && w <= `IDX_STATUS);
    endfunction

    // arbitration: lowest number, or best identifier with ties to lower number
    function automatic logic [MB_W:0] pick(input logic [NUM_MB-1:0] elig,
                                           input logic by_id,
                                           input logic [NUM_MB*ID_W-1:0] idv);
        logic found;
        logic [ID_W-1:0] best;
        logic [MB_W-1:0] idx;
        found = 1'b0;
        best = '1;
        idx = '0;
        for (int i = NUM_MB - 1; i >= 0; i--) begin
            if (elig[i] && (!by_id || !found || idv[i*ID_W +: ID_W] <= best)) begin
                found = 1'b1;
                best = idv[i*ID_W +: ID_W];
                idx = MB_W'(i);
            end
        end
        pick = {found, idx};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus slave state
    logic aw_full, w_full;
    logic next_aw_full, next_w_full;
    logic [WA_W-1:0] aw_word, next_aw_word;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_go;

    // mailbox state
    logic [NUM_MB-1:0] mailbox_enable, next_mailbox_enable;
    logic [NUM_MB-1:0] mailbox_direction, next_mailbox_direction;
    logic [NUM_MB-1:0] transmit_request, next_transmit_request;
    logic [NUM_MB-1:0] cancel_request, next_cancel_request;
    logic [NUM_MB-1:0] transmit_acknowledge, next_transmit_acknowledge;
    logic [NUM_MB-1:0] abort_acknowledge, next_abort_acknowledge;
    logic [NUM_MB-1:0] auto_remote_reply, next_auto_remote_reply;
    logic [NUM_MB*ID_W-1:0] ids, next_ids;
    logic [NUM_MB*DLC_W-1:0] dlcs, next_dlcs;
    logic [MB_W-1:0] sel, next_sel;
    logic transmit_order_select, next_transmit_order_select;
    tx_state_t state, next_state;
    logic [MB_W-1:0] cur, next_cur;
    logic [ID_W-1:0] next_tx_id;
    logic [DLC_W-1:0] next_tx_dlc;
    logic next_rx_stop;

    // helpers
    logic [NUM_MB-1:0] tx_dir, eligible;
    logic [MB_W:0] win;
    logic sel_lock, sending;
    logic [ID_W-1:0] sel_id;

    assign awready = !aw_full;
    assign wready = !w_full;
    assign arready = !rvalid;
    assign wr_go = aw_full && w_full && !bvalid;
    assign tx_req = (state == TX_OFFER);
    assign tx_mailbox = cur;

    // mailbox 15 never transmits
    assign tx_dir = {1'b0, ~mailbox_direction[NUM_MB-2:0]};
    // a mailbox with a pending cancel is never offered again, so a dropped request cannot be sent
    assign eligible = transmit_request & ~cancel_request & mailbox_enable & tx_dir;
    assign win = pick(eligible, transmit_order_select, ids);
    assign sel_lock = transmit_request[sel] || cancel_request[sel];
    assign sel_id = ids[sel*ID_W +: ID_W];
    assign sending = (state == TX_SEND) || (state == TX_OFFER && tx_start);

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes and read data
    always_comb begin
        next_aw_full = aw_full;
        next_aw_word = aw_word;
        next_w_full = w_full;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (awvalid && awready) begin
            next_aw_full = 1'b1;
            next_aw_word = awaddr[ADDR_W-1:2];
        end
        if (wvalid && wready) begin
            next_w_full = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_go) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = is_mapped(aw_word) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = is_mapped(araddr[ADDR_W-1:2]) ? `RESP_OKAY : `RESP_SLVERR;
            next_rdata = '0;
            case (araddr[ADDR_W-1:2])
                `IDX_ENABLE_LO: next_rdata[7:0] = mailbox_enable[7:0];
                `IDX_ENABLE_HI: next_rdata[7:0] = mailbox_enable[15:8];
                `IDX_DIR_LO: next_rdata[7:0] = mailbox_direction[7:0];
                `IDX_DIR_HI: next_rdata[7:0] = mailbox_direction[15:8];
                `IDX_REQ_LO: next_rdata[7:0] = transmit_request[7:0];
                `IDX_REQ_HI: next_rdata[7:0] = transmit_request[15:8];
                `IDX_CAN_LO: next_rdata[7:0] = cancel_request[7:0];
                `IDX_CAN_HI: next_rdata[7:0] = cancel_request[15:8];
                `IDX_ACK_LO: next_rdata[7:0] = transmit_acknowledge[7:0];
                `IDX_ACK_HI: next_rdata[7:0] = transmit_acknowledge[15:8];
                `IDX_ABT_LO: next_rdata[7:0] = abort_acknowledge[7:0];
                `IDX_ABT_HI: next_rdata[7:0] = abort_acknowledge[15:8];
                `IDX_SELECT: next_rdata[MB_W-1:0] = sel;
                `IDX_IDENT: next_rdata[ID_W-1:0] = sel_id;
                `IDX_CONTROL: begin
                    next_rdata[DLC_W-1:0] = dlcs[sel*DLC_W +: DLC_W];
                    next_rdata[`RFH_BIT] = auto_remote_reply[sel];
                end
                `IDX_MASTER: next_rdata[`ORDER_SEL_BIT] = transmit_order_select;
                `IDX_STATUS: next_rdata[MB_W+1:0] =
                    {state == TX_SEND, state == TX_OFFER, cur};
                default: next_rdata = '0;
            endcase
        end
    end

    // bus registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_word <= '0;
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `RESP_OKAY;
            rdata <= '0;
        end else begin
            aw_full <= next_aw_full;
            aw_word <= next_aw_word;
            w_full <= next_w_full;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes, cancellation and transmit sequencing
    always_comb begin
        logic [NUM_MB-1:0] set_req, set_can, clr_ack, clr_abt;
        logic [7:0] wd;
        logic wl;
        set_req = '0;
        set_can = '0;
        clr_ack = '0;
        clr_abt = '0;
        wd = w_data[7:0];
        wl = wr_go && w_strb[0];
        next_mailbox_enable = mailbox_enable;
        next_mailbox_direction = mailbox_direction;
        next_transmit_request = transmit_request;
        next_cancel_request = cancel_request;
        next_transmit_acknowledge = transmit_acknowledge;
        next_abort_acknowledge = abort_acknowledge;
        next_auto_remote_reply = auto_remote_reply;
        next_ids = ids;
        next_dlcs = dlcs;
        next_sel = sel;
        next_transmit_order_select = transmit_order_select;
        next_state = state;
        next_cur = cur;
        if (wl) begin
            case (aw_word)
                `IDX_ENABLE_LO: next_mailbox_enable[7:0] = wd;
                `IDX_ENABLE_HI: next_mailbox_enable[15:8] = wd;
                `IDX_DIR_LO: next_mailbox_direction[7:0] = wd;
                `IDX_DIR_HI: next_mailbox_direction[15:8] = wd;
                `IDX_REQ_LO: set_req[7:0] = wd;
                `IDX_REQ_HI: set_req[15:8] = wd;
                `IDX_CAN_LO: set_can[7:0] = wd;
                `IDX_CAN_HI: set_can[15:8] = wd;
                `IDX_ACK_LO: clr_ack[7:0] = wd;
                `IDX_ACK_HI: clr_ack[15:8] = wd;
                `IDX_ABT_LO: clr_abt[7:0] = wd;
                `IDX_ABT_HI: clr_abt[15:8] = wd;
                `IDX_SELECT: next_sel = wd[MB_W-1:0];
                `IDX_IDENT: begin
                    if (!sel_lock) begin
                        next_ids[sel*ID_W +: 8] = wd;
                        if (w_strb[1]) begin
                            next_ids[sel*ID_W+8 +: ID_W-8] = w_data[ID_W-1:8];
                        end
                    end
                end
                `IDX_CONTROL: begin
                    // auto-reply mailboxes keep their control field while enabled
                    if (!sel_lock && !(auto_remote_reply[sel] && mailbox_enable[sel])) begin
                        next_dlcs[sel*DLC_W +: DLC_W] = wd[DLC_W-1:0];
                        next_auto_remote_reply[sel] = wd[`RFH_BIT];
                    end
                end
                `IDX_MASTER: next_transmit_order_select = wd[`ORDER_SEL_BIT];
                default: ;
            endcase
        end
        next_mailbox_direction[NUM_MB-1] = 1'b1;
        // software clears of the flags go first so that hardware sets win
        next_transmit_acknowledge = next_transmit_acknowledge & ~(clr_ack | set_req);
        next_abort_acknowledge = next_abort_acknowledge & ~(clr_abt | set_req);
        // drop cancelled requests that have not started
        for (int i = 0; i < NUM_MB; i++) begin
            if (cancel_request[i] && !(sending && cur == MB_W'(i))) begin
                next_transmit_request[i] = 1'b0;
                next_cancel_request[i] = 1'b0;
                next_abort_acknowledge[i] = 1'b1;
            end
        end
        case (state)
            TX_IDLE: begin
                if (win[MB_W]) begin
                    next_cur = win[MB_W-1:0];
                    next_state = TX_OFFER;
                end
            end
            TX_OFFER: begin
                if (tx_start) begin
                    next_state = TX_SEND;
                end else if (!win[MB_W]) begin
                    next_state = TX_IDLE;
                end else begin
                    next_cur = win[MB_W-1:0];
                end
            end
            TX_SEND: begin
                if (tx_ok) begin
                    next_transmit_request[cur] = 1'b0;
                    next_cancel_request[cur] = 1'b0;
                    next_transmit_acknowledge[cur] = 1'b1;
                    next_state = TX_IDLE;
                end else if (tx_fail) begin
                    if (cancel_request[cur]) begin
                        next_transmit_request[cur] = 1'b0;
                        next_cancel_request[cur] = 1'b0;
                        next_abort_acknowledge[cur] = 1'b1;
                    end
                    // without a pending cancel the request stays set, so a new arbitration run retries it
                    next_state = TX_IDLE;
                end
            end
            default: next_state = TX_IDLE;
        endcase
        // software sets come last; receive mailboxes ignore them
        next_transmit_request = next_transmit_request | (set_req & tx_dir);
        next_cancel_request = next_cancel_request | (set_can & tx_dir & transmit_request);
        next_tx_id = next_ids[next_cur*ID_W +: ID_W];
        next_tx_dlc = next_dlcs[next_cur*DLC_W +: DLC_W];
        // reception of a mailbox being disabled is stopped
        next_rx_stop = rx_active && mailbox_enable[rx_mailbox] &&
                       !next_mailbox_enable[rx_mailbox];
    end

    // mailbox registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mailbox_enable <= `EN_RESET;
            mailbox_direction <= `DIR_RESET;
            transmit_request <= '0;
            cancel_request <= '0;
            transmit_acknowledge <= '0;
            abort_acknowledge <= '0;
            auto_remote_reply <= '0;
            ids <= '0;
            dlcs <= '0;
            sel <= '0;
            transmit_order_select <= 1'b0;
            state <= TX_IDLE;
            cur <= '0;
            tx_id <= '0;
            tx_dlc <= '0;
            rx_stop <= 1'b0;
        end else begin
            mailbox_enable <= next_mailbox_enable;
            mailbox_direction <= next_mailbox_direction;
            transmit_request <= next_transmit_request;
            cancel_request <= next_cancel_request;
            transmit_acknowledge <= next_transmit_acknowledge;
            abort_acknowledge <= next_abort_acknowledge;
            auto_remote_reply <= next_auto_remote_reply;
            ids <= next_ids;
            dlcs <= next_dlcs;
            sel <= next_sel;
            transmit_order_select <= next_transmit_order_select;
            state <= next_state;
            cur <= next_cur;
            tx_id <= next_tx_id;
            tx_dlc <= next_tx_dlc;
            rx_stop <= next_rx_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_id_lock;
        @(posedge aclk) disable iff (!aresetn)
        (wr_go && w_strb[0] && aw_word == `IDX_IDENT && sel_lock) |=> $stable(sel_id);
    endproperty
    a_id_lock: assert property (p_id_lock) else $error("locked identifier changed");

    property p_dir15_read;
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && araddr[ADDR_W-1:2] == `IDX_DIR_HI) |=> rdata[7];
    endproperty
    a_dir15_read: assert property (p_dir15_read) else $error("direction 15 read as 0");

    property p_no_req15;
        @(posedge aclk) disable iff (!aresetn)
        !transmit_request[NUM_MB-1] && !cancel_request[NUM_MB-1];
    endproperty
    a_no_req15: assert property (p_no_req15) else $error("bit 15 request set");

    property p_rx_ignore;
        @(posedge aclk) disable iff (!aresetn)
        (wr_go && w_strb[0] && aw_word == `IDX_REQ_LO && mailbox_direction[0]
         && !transmit_request[0]) |=> !transmit_request[0];
    endproperty
    a_rx_ignore: assert property (p_rx_ignore) else $error("receive mailbox requested");

    property p_success;
        @(posedge aclk) disable iff (!aresetn)
        (state == TX_SEND && tx_ok) |=> !transmit_request[$past(cur)]
            && transmit_acknowledge[$past(cur)] && state == TX_IDLE;
    endproperty
    a_success: assert property (p_success) else $error("success not recorded");

    property p_abort;
        @(posedge aclk) disable iff (!aresetn)
        (state == TX_SEND && !tx_ok && tx_fail && cancel_request[cur])
            |=> abort_acknowledge[$past(cur)] && !cancel_request[$past(cur)];
    endproperty
    a_abort: assert property (p_abort) else $error("abort not recorded");

    property p_retry;
        @(posedge aclk) disable iff (!aresetn)
        (state == TX_SEND && !tx_ok && tx_fail && !cancel_request[cur])
            |=> transmit_request[$past(cur)] && state == TX_IDLE;
    endproperty
    a_retry: assert property (p_retry) else $error("failed request lost");

    property p_lowest;
        @(posedge aclk) disable iff (!aresetn)
        (state == TX_IDLE && eligible != '0 && !transmit_order_select)
            ##1 1'b1 |-> ($past(eligible) & ((16'h0001 << cur) - 16'h0001)) == 16'h0000;
    endproperty
    a_lowest: assert property (p_lowest) else $error("not lowest mailbox");

    property p_cancel_idle;
        @(posedge aclk) disable iff (!aresetn)
        (state == TX_IDLE && cancel_request != '0) |=>
            (transmit_request & $past(cancel_request)) == '0 &&
            (abort_acknowledge & $past(cancel_request)) == $past(cancel_request);
    endproperty
    a_cancel_idle: assert property (p_cancel_idle) else $error("idle cancel kept");
endmodule
`default_nettype wire

// File: rtl/can_mbox_map.svh
// register indices, field positions and reset values of the mailbox control block
`ifndef CAN_MBOX_MAP_SVH
`define CAN_MBOX_MAP_SVH
// register indices; byte address is four times the index
`define IDX_ENABLE_LO 10'h300
`define IDX_ENABLE_HI 10'h301
`define IDX_DIR_LO 10'h302
`define IDX_DIR_HI 10'h303
`define IDX_REQ_LO 10'h304
`define IDX_REQ_HI 10'h305
`define IDX_CAN_LO 10'h306
`define IDX_CAN_HI 10'h307
`define IDX_ACK_LO 10'h308
`define IDX_ACK_HI 10'h309
`define IDX_ABT_LO 10'h30a
`define IDX_ABT_HI 10'h30b
`define IDX_SELECT 10'h310
`define IDX_IDENT 10'h311
`define IDX_CONTROL 10'h312
`define IDX_MASTER 10'h313
`define IDX_STATUS 10'h314
// field positions
`define ORDER_SEL_BIT 3
`define RFH_BIT 4
// reset values
`define DIR_RESET 16'h8000
`define EN_RESET 16'h0000
// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: rtl/can_mbox_pkg.sv
// types shared by the mailbox control block
package can_mbox_pkg;
    typedef enum {TX_IDLE, TX_OFFER, TX_SEND} tx_state_t;
endpackage

// File: dv/can_engine_model.sv
// bus engine model: takes offers, sends for a while, fails on command
`timescale 1ns/100ps
`default_nettype none
module can_engine_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_req,
    input wire logic [3:0] fails,
    output logic tx_start,
    output logic tx_ok,
    output logic tx_fail
);
    int cnt;
    int nfail;
    logic busy;
    ////////////////////////////////////////////////////////////////////////////////
    // take an offer, count out a frame, then report the outcome
    always @(posedge aclk) begin
        tx_start <= 1'b0;
        tx_ok <= 1'b0;
        tx_fail <= 1'b0;
        if (!aresetn) begin
            busy <= 1'b0;
            nfail <= 0;
        end else if (!busy && tx_req) begin
            tx_start <= 1'b1;
            busy <= 1'b1;
            cnt <= 8;
        end else if (busy && cnt > 0) begin
            cnt <= cnt - 1;
        end else if (busy) begin
            busy <= 1'b0;
            if (nfail < int'(fails)) begin
                tx_fail <= 1'b1; // lost arbitration or error
                nfail <= nfail + 1;
            end else begin
                tx_ok <= 1'b1;
                nfail <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/can_mailbox_tx_request_control_test.sv
// self-checking bench of the mailbox transmit request control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module can_mailbox_tx_request_control_test;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, rx_active = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] rx_mailbox = 0, tx_mailbox, tx_dlc, fails = 0;
    logic awready, wready, bvalid, arready, rvalid, rx_stop, tx_req, tx_start, tx_ok, tx_fail;
    logic [1:0] bresp, rresp, last_resp;
    logic [10:0] tx_id;
    logic [15:0] seq = 16'hffff;
    logic stop_seen = 0;
    logic [14:0] mb4_tx = 0;
    int miscompares = 0, num_checks = 0;
    can_mailbox_tx_request_control i_can_mailbox_tx_request_control (.aclk(aclk),
        .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .tx_req(tx_req),
        .tx_mailbox(tx_mailbox), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_start(tx_start),
        .tx_ok(tx_ok), .tx_fail(tx_fail), .rx_active(rx_active), .rx_mailbox(rx_mailbox),
        .rx_stop(rx_stop));
    can_engine_model i_can_engine_model (.aclk(aclk), .aresetn(aresetn), .tx_req(tx_req),
        .fails(fails), .tx_start(tx_start), .tx_ok(tx_ok), .tx_fail(tx_fail));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    always #20 aclk = ~aclk;
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        report_and_stop();
    end
    // log each taken offer and any reception stop
    always @(negedge aclk) begin
        if (aresetn && tx_start && tx_req) seq <= {seq[11:0], tx_mailbox};
        if (aresetn && tx_start && tx_req && tx_mailbox == 4'h4) mb4_tx <= {tx_dlc, tx_id};
        if (rx_stop) stop_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // bus tasks
    task automatic axw(input logic [11:0] a, input logic [10:0] d);
        logic ta, tw, b;
        awaddr <= a;
        wdata <= {21'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            b = bvalid;
            last_resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!b);
    endtask
    task automatic axr(input logic [11:0] a);
        logic t, v;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            t = arvalid && arready;
            v = rvalid;
            rd = rdata;
            last_resp = rresp;
            @(posedge aclk);
            if (t) arvalid <= 1'b0;
        end while (!v);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [10:0] e);
        axr(a);
        `CHK($sformatf("reg %h", a), {21'h0, e}, rd)
    endtask
    // poll the low request register until all sends are over
    task automatic idle_wait();
        int n;
        n = 0;
        do begin
            axr(12'hc10);
            n++;
        end while (rd[7:0] !== 8'h00 && n < 200);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(12'hc00, 11'h000);
        rchk(12'hc0c, 11'h080);
        axw(12'hc0c, 11'h000);
        rchk(12'hc0c, 11'h080);
        axw(12'hc08, 11'h001);
        axw(12'hc10, 11'h001);
        rchk(12'hc10, 11'h000);
        axw(12'hc18, 11'h001);
        rchk(12'hc18, 11'h000);
        axw(12'hc08, 11'h000);
        axw(12'hffc, 11'h001);
        `CHK("unmapped", 2'b10, last_resp)
        rchk(12'hffc, 11'h000);
        `CHK("unmapped read", 2'b10, last_resp)
        $display("test registers done");
        axw(12'hc40, 11'h003);
        axw(12'hc44, 11'h100);
        axw(12'hc40, 11'h004);
        axw(12'hc44, 11'h050);
        axw(12'hc48, 11'h005);
        axw(12'hc00, 11'h0ff);
        axw(12'hc10, 11'h024);
        while (seq === 16'hffff) @(posedge aclk);
        axw(12'hc10, 11'h001);
        idle_wait();
        `CHK("order", 16'hf205, seq)
        rchk(12'hc20, 11'h025);
        axw(12'hc20, 11'h025);
        rchk(12'hc20, 11'h000);
        fails <= 4'h2;
        seq <= 16'hffff;
        axw(12'hc10, 11'h002);
        idle_wait();
        `CHK("retry", 16'hf111, seq)
        rchk(12'hc20, 11'h002);
        fails <= 4'h0;
        axw(12'hc4c, 11'h008);
        seq <= 16'hffff;
        axw(12'hc10, 11'h018);
        idle_wait();
        `CHK("by id", 16'hff43, seq)
        `CHK("mb4 frame", 15'h2850, mb4_tx)
        seq <= 16'hffff;
        axw(12'hc10, 11'h002);
        while (seq === 16'hffff) @(posedge aclk);
        axw(12'hc18, 11'h002);
        idle_wait();
        rchk(12'hc20, 11'h01a);
        rchk(12'hc18, 11'h000);
        fails <= 4'h1;
        seq <= 16'hffff;
        axw(12'hc10, 11'h002);
        while (seq === 16'hffff) @(posedge aclk);
        axw(12'hc18, 11'h002);
        idle_wait();
        `CHK("abort", 16'hfff1, seq)
        rchk(12'hc28, 11'h002);
        axw(12'hc28, 11'h002);
        rchk(12'hc28, 11'h000);
        fails <= 4'h0;
        $display("test sending done");
        seq <= 16'hffff;
        axw(12'hc00, 11'h0bf);
        axw(12'hc10, 11'h040);
        rchk(12'hc10, 11'h040);
        axw(12'hc40, 11'h006);
        axw(12'hc44, 11'h123);
        rchk(12'hc44, 11'h000);
        axw(12'hc18, 11'h040);
        rchk(12'hc18, 11'h000);
        rchk(12'hc10, 11'h000);
        rchk(12'hc28, 11'h040);
        `CHK("no send", 16'hffff, seq)
        $display("test cancel done");
        rx_mailbox <= 4'h7;
        rx_active <= 1'b1;
        axw(12'hc00, 11'h03f);
        axr(12'hc00);
        `CHK("rx stop", 1'b1, stop_seen)
        $display("test reception done");
        report_and_stop();
    end
endmodule
`default_nettype wire
